/* File: verilog/pse_regs_pkg.sv */
// Register map, field layout and carriers for the quad port event/status bank
package pse_regs_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_INT_SUMMARY  = 8'h00;
   localparam logic [7:0] ADDR_INT_MASK     = 8'h01;
   localparam logic [7:0] ADDR_PWR_EVT      = 8'h02;
   localparam logic [7:0] ADDR_PWR_EVT_CLR  = 8'h03;
   localparam logic [7:0] ADDR_DET_EVT      = 8'h04;
   localparam logic [7:0] ADDR_DET_EVT_CLR  = 8'h05;
   localparam logic [7:0] ADDR_FLT_EVT      = 8'h06;
   localparam logic [7:0] ADDR_FLT_EVT_CLR  = 8'h07;
   localparam logic [7:0] ADDR_START_EVT    = 8'h08;
   localparam logic [7:0] ADDR_START_EVT_CLR = 8'h09;
   localparam logic [7:0] ADDR_SUP_EVT      = 8'h0A;
   localparam logic [7:0] ADDR_SUP_EVT_CLR  = 8'h0B;
   localparam logic [7:0] ADDR_PORT1_RESULT = 8'h0C;
   localparam logic [7:0] ADDR_PORT4_RESULT = 8'h0F;
   localparam logic [7:0] ADDR_PWR_STATUS   = 8'h10;
   localparam logic [7:0] ADDR_STRAP_LEVELS = 8'h11;
   localparam logic [7:0] ADDR_PORT_MODE    = 8'h12;
   localparam logic [7:0] ADDR_LOW_CUR_EN   = 8'h13;
   localparam logic [7:0] ADDR_DET_CLASS_EN = 8'h14;
   localparam logic [7:0] ADDR_FAULT_TIMER  = 8'h16;
   localparam logic [7:0] ADDR_MISC_CFG     = 8'h17;
   localparam logic [7:0] ADDR_RESET_PB     = 8'h1A;

   // Reset values
   localparam logic [7:0] EVENT_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [7:0] MODE_RESET     = 8'h00;
   localparam logic [7:0] CFG_RESET      = 8'h00;
   localparam logic [7:0] MISC_RESET     = 8'h80;
   localparam logic [7:0] RESULT_RESET   = 8'h00;

   // Field positions
   localparam int MISC_INT_EN_BIT   = 7;
   localparam int RSTPB_CLR_ALL_BIT = 7;
   localparam int RSTPB_RELEASE_BIT = 6;
   localparam int SUP_VEE_UV_BIT    = 4;
   localparam int SUP_VDD_UV_BIT    = 5;
   localparam int SUP_TEMP_BIT      = 7;
   localparam int TMR_DIS_LSB       = 0;
   localparam int TMR_OVERCURRENT_LIMIT_LSB      = 2;
   localparam int TMR_START_LSB     = 4;
   localparam int RESULT_CLASS_LSB  = 4;
   localparam int STRAP_AUTO_BIT    = 0;
   localparam int STRAP_ADDR_LSB    = 2;

   // Summary bit layout
   localparam int SUM_PWR_EN   = 0;
   localparam int SUM_PWR_GOOD = 1;
   localparam int SUM_DET_DONE = 2;
   localparam int SUM_CLS_DONE = 3;
   localparam int SUM_OVERCURRENT_LIMIT     = 4;
   localparam int SUM_START    = 5;
   localparam int SUM_DISCON   = 6;
   localparam int SUM_SUPPLY   = 7;

   // Port mode encoding
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_MANUAL   = 2'h1;
   localparam logic [1:0] MODE_SEMI     = 2'h2;
   localparam logic [1:0] MODE_AUTO     = 2'h3;

   // Strap start-up sequence
   typedef enum logic [1:0] {
      STRAP_SETTLE_A,
      STRAP_SETTLE_B,
      STRAP_LOAD,
      STRAP_DONE
   } strap_state_t;

   // Reports from the per-port analog engines, same clock domain
   typedef struct packed {
      logic [3:0]      pwr_on;       // switch state
      logic [3:0]      pwr_good;     // drop low and start-up complete
      logic [3:0]      det_done;     // pulse per finished detection
      logic [3:0]      class_done;   // pulse per finished classification
      logic [3:0][2:0] det_result;
      logic [3:0][2:0] class_result;
      logic [3:0]      overcurrent_limit_fault;   // still over limit at window end
      logic [3:0]      start_fault;
      logic [3:0]      low_current;  // under hold level past delay
      logic            vee_undervoltage_lockout;
      logic            vdd_undervoltage_lockout;
      logic            over_temp;
   } engine_report_t;

   // Controls handed to the per-port engines
   typedef struct packed {
      logic [7:0] port_mode;
      logic [3:0] disc_en;
      logic [3:0] det_en;
      logic [3:0] class_en;
      logic [3:0] det_run;          // one-cycle manual run
      logic [3:0] class_run;
      logic [3:0] remove_power;     // turn-off order, high one clock after each cycle of its cause
      logic [1:0] disconnect_delay;
      logic [1:0] overcurrent_window;
      logic [1:0] startup_window;
   } engine_ctrl_t;

endpackage : pse_regs_pkg

/* File: verilog/event_latch.sv */
// Sticky eight-bit event register with clear-after-read alias support
module event_latch
   import pse_regs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Events and clear
   input  wire logic [7:0] set_in,
   input  wire logic       clr,
   // Latched value
   output logic      [7:0] value_q
);

   // Set wins over clear so an event on the clearing edge survives
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         value_q <= EVENT_RESET;
      end else begin
         value_q <= (clr ? EVENT_RESET : value_q) | set_in;
      end
   end

endmodule : event_latch

/* File: verilog/pse_event_regs.sv */
// Event, status and configuration register bank of a four-port power controller
// Functional notes
// - Unmasked summary bit rising from 0 to 1 asserts the alert line.
// - Summary bits are ORs of event bits, read only, cleared via events or reset.
// - Mask gates summary onto alert; summary itself ignores the mask.
// - Power events latch on enable change (3:0) and good change (7:4).
// - Alias one address up reads same value and clears the event register.
// - Detect events latch on detection done (3:0), classification done (7:4).
// - Detect event means idle in manual, results valid in other modes.
// - Fault events latch on overcurrent window (3:0) and disconnect (7:4).
// - Start-up events latch per port in 3:0; upper bits read zero.
// - Supply events: bit4 negative UV, bit5 logic UV, bit7 thermal.
// - Port result holds detect 2:0 and class 6:4, cleared at power off.
// - Power status shows switch state and sticky power-good until off.
// - Strap status shows live autostart at bit0, address straps bits 2-5.
// - Port mode loads sampled autostart strap at power-up only.
// - Disconnect enable lets low current past delay remove port power.
// - Detect/class enable bits; in manual mode a set bit runs one cycle.
// - Timing bits select delays; overcurrent at window end turns port off.
// - Modes: 00 shutdown, 01 manual, 10 semiautomatic, 11 automatic.
// - Misc bit 7, set at reset, enables alert and alert response.
// - Reset pushbutton bit 7 releases alert and clears events and summary.
module pse_event_regs
   import pse_regs_pkg::*;
(
   // Clock and reset
   input  wire logic           clk_sys,
   input  wire logic           sys_rst,
   // Register access from the serial bus engine
   input  wire logic [7:0]     reg_addr,
   input  wire logic           reg_wr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_rd,
   output logic      [7:0]     reg_rdata_q,
   output logic                reg_rvalid_q,
   output logic                alert_resp_en_q,
   // Port engines
   input  wire engine_report_t eng_rpt,
   output engine_ctrl_t        eng_ctrl_q,
   // Strap pins
   input  wire logic           auto_strap,
   input  wire logic [3:0]     bus_addr_straps,
   // Open-drain alert pin
   input  wire logic           alert_i,
   output logic                alert_o_q,
   output logic                alert_oe_q
);

   // OR of a four-bit port group
   function automatic logic any_of(input logic [3:0] v);
      return |v;
   endfunction : any_of

   // Address match for one register, used for write and read strobes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      return a == target;
   endfunction : hit

   logic [7:0]   mask_q;
   logic [7:0]   misc_q;
   logic [7:0]   mode_q;
   logic [3:0]   disc_en_q;
   logic [7:0]   det_class_en_q;
   logic [7:0]   timer_sel_q;
   logic [3:0]   pwr_on_q;
   logic [3:0]   pwr_good_q;
   logic [3:0]   pwr_on_prev_q;
   logic [3:0]   pwr_good_prev_q;
   logic [7:0]   result_q [4];
   logic [7:0]   summary_d;
   logic [7:0]   summary_q;
   logic [7:0]   pending_q;
   logic [4:0]   strap_meta_q;
   logic [4:0]   strap_sync_q;
   strap_state_t strap_state_q;
   logic [7:0]   pwr_evt_set;
   logic [7:0]   det_evt_set;
   logic [7:0]   flt_evt_set;
   logic [7:0]   start_evt_set;
   logic [7:0]   sup_evt_set;
   logic [7:0]   pwr_evt_q;
   logic [7:0]   det_evt_q;
   logic [7:0]   flt_evt_q;
   logic [7:0]   start_evt_q;
   logic [7:0]   sup_evt_q;
   logic         clr_all;
   logic         release_pin;
   logic [3:0]   discon_now;
   logic [3:0]   manual_port;

   // Pushbutton decode; the pushbutton register itself stores nothing
   assign clr_all     = reg_wr && hit(reg_addr, ADDR_RESET_PB)
                        && reg_wdata[RSTPB_CLR_ALL_BIT];
   assign release_pin = reg_wr && hit(reg_addr, ADDR_RESET_PB)
                        && reg_wdata[RSTPB_RELEASE_BIT];

   // Removal only where the enable allows it
   assign discon_now = eng_rpt.low_current & disc_en_q;

   // Ports currently in manual mode
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         manual_port[p] = (mode_q[2*p +: 2] == MODE_MANUAL);
      end
   end

   // Event sources
   assign pwr_evt_set   = {pwr_good_q ^ pwr_good_prev_q, pwr_on_q ^ pwr_on_prev_q};
   assign det_evt_set   = {eng_rpt.class_done, eng_rpt.det_done};
   assign flt_evt_set   = {discon_now, eng_rpt.overcurrent_limit_fault};
   assign start_evt_set = {4'h0, eng_rpt.start_fault};
   always_comb begin
      sup_evt_set                 = 8'h00;
      sup_evt_set[SUP_VEE_UV_BIT] = eng_rpt.vee_undervoltage_lockout;
      sup_evt_set[SUP_VDD_UV_BIT] = eng_rpt.vdd_undervoltage_lockout;
      sup_evt_set[SUP_TEMP_BIT]   = eng_rpt.over_temp;
   end

   // Sticky event registers; alias read or clear-all wipes them
   event_latch u_pwr_evt (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_in  (pwr_evt_set),
      .clr     (clr_all || (reg_rd && hit(reg_addr, ADDR_PWR_EVT_CLR))),
      .value_q (pwr_evt_q)
   );
   event_latch u_det_evt (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_in  (det_evt_set),
      .clr     (clr_all || (reg_rd && hit(reg_addr, ADDR_DET_EVT_CLR))),
      .value_q (det_evt_q)
   );
   event_latch u_flt_evt (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_in  (flt_evt_set),
      .clr     (clr_all || (reg_rd && hit(reg_addr, ADDR_FLT_EVT_CLR))),
      .value_q (flt_evt_q)
   );
   event_latch u_start_evt (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_in  (start_evt_set),
      .clr     (clr_all || (reg_rd && hit(reg_addr, ADDR_START_EVT_CLR))),
      .value_q (start_evt_q)
   );
   event_latch u_sup_evt (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .set_in  (sup_evt_set),
      .clr     (clr_all || (reg_rd && hit(reg_addr, ADDR_SUP_EVT_CLR))),
      .value_q (sup_evt_q)
   );

   // Summary is a pure OR of latched events, never written, mask-free
   always_comb begin
      summary_d               = 8'h00;
      summary_d[SUM_PWR_EN]   = any_of(pwr_evt_q[3:0]);
      summary_d[SUM_PWR_GOOD] = any_of(pwr_evt_q[7:4]);
      summary_d[SUM_DET_DONE] = any_of(det_evt_q[3:0]);
      summary_d[SUM_CLS_DONE] = any_of(det_evt_q[7:4]);
      summary_d[SUM_OVERCURRENT_LIMIT]     = any_of(flt_evt_q[3:0]);
      summary_d[SUM_START]    = any_of(start_evt_q[3:0]);
      summary_d[SUM_DISCON]   = any_of(flt_evt_q[7:4]);
      summary_d[SUM_SUPPLY]   = |sup_evt_q;
   end

   // Registered summary, also the reference for rising-edge detection
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         summary_q <= EVENT_RESET;
      end else begin
         summary_q <= summary_d;
      end
   end

   // Per-bit alert arming: a rising unmasked bit arms, a release disarms;
   // once released the bit must fall and rise again to re-arm
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pending_q <= EVENT_RESET;
      end else if (release_pin || clr_all) begin
         pending_q <= EVENT_RESET;
      end else begin
         pending_q <= (pending_q & summary_d) | (summary_d & ~summary_q & mask_q);
      end
   end

   // Open-drain alert: drive low while any armed bit is still unmasked
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alert_oe_q <= 1'b0;
         alert_o_q  <= 1'b0;
      end else begin
         alert_oe_q <= |(pending_q & mask_q) && misc_q[MISC_INT_EN_BIT];
         alert_o_q  <= 1'b0;
      end
   end

   // Alert-response participation follows the enable bit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alert_resp_en_q <= MISC_RESET[MISC_INT_EN_BIT];
      end else begin
         alert_resp_en_q <= misc_q[MISC_INT_EN_BIT];
      end
   end

   // Straps come from pins: two flops before anything reads them
   always_ff @(posedge clk_sys) begin
      strap_meta_q <= {bus_addr_straps, auto_strap};
      strap_sync_q <= strap_meta_q;
   end

   // Power-up sequence waits for the synchroniser, then samples autostart
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         strap_state_q <= STRAP_SETTLE_A;
      end else begin
         case (strap_state_q)
            STRAP_SETTLE_A: strap_state_q <= STRAP_SETTLE_B;
            STRAP_SETTLE_B: strap_state_q <= STRAP_LOAD;
            STRAP_LOAD:     strap_state_q <= STRAP_DONE;
            STRAP_DONE:     strap_state_q <= STRAP_DONE;
            default:        strap_state_q <= STRAP_SETTLE_A;
         endcase
      end
   end

   // Mode register: strap only seeds it, software owns it afterwards
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mode_q <= MODE_RESET;
      end else if (strap_state_q == STRAP_LOAD) begin
         mode_q <= {8{strap_sync_q[STRAP_AUTO_BIT]}};
      end else if (reg_wr && hit(reg_addr, ADDR_PORT_MODE)) begin
         mode_q <= reg_wdata;
      end
   end

   // Plain read/write configuration
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mask_q         <= MASK_RESET;
         misc_q         <= MISC_RESET;
         disc_en_q      <= CFG_RESET[3:0];
         det_class_en_q <= CFG_RESET;
         timer_sel_q    <= CFG_RESET;
      end else if (reg_wr) begin
         if (hit(reg_addr, ADDR_INT_MASK)) begin
            mask_q <= reg_wdata;
         end
         if (hit(reg_addr, ADDR_MISC_CFG)) begin
            misc_q <= reg_wdata & MISC_RESET;
         end
         if (hit(reg_addr, ADDR_LOW_CUR_EN)) begin
            disc_en_q <= reg_wdata[3:0];
         end
         if (hit(reg_addr, ADDR_DET_CLASS_EN)) begin
            det_class_en_q <= reg_wdata;
         end
         if (hit(reg_addr, ADDR_FAULT_TIMER)) begin
            timer_sel_q <= {2'h0, reg_wdata[5:0]};
         end
      end
   end

   // Power state tracking; power-good sticks until the switch opens
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pwr_on_q        <= CFG_RESET[3:0];
         pwr_good_q      <= CFG_RESET[3:0];
         pwr_on_prev_q   <= CFG_RESET[3:0];
         pwr_good_prev_q <= CFG_RESET[3:0];
      end else begin
         pwr_on_q        <= eng_rpt.pwr_on;
         pwr_good_q      <= (pwr_good_q | eng_rpt.pwr_good) & eng_rpt.pwr_on;
         pwr_on_prev_q   <= pwr_on_q;
         pwr_good_prev_q <= pwr_good_q;
      end
   end

   // Results freeze while powered and vanish once power is gone
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int p = 0; p < 4; p++) begin
            result_q[p] <= RESULT_RESET;
         end
      end else begin
         for (int p = 0; p < 4; p++) begin
            if (pwr_on_prev_q[p] && !pwr_on_q[p]) begin
               result_q[p] <= RESULT_RESET;
            end else if (!pwr_on_q[p]) begin
               if (eng_rpt.det_done[p]) begin
                  result_q[p][2:0] <= eng_rpt.det_result[p];
               end
               if (eng_rpt.class_done[p]) begin
                  result_q[p][RESULT_CLASS_LSB +: 3] <= eng_rpt.class_result[p];
               end
            end
         end
      end
   end

   // Controls to the port engines; manual runs fire once per written one
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         eng_ctrl_q <= '0;
      end else begin
         eng_ctrl_q.port_mode          <= mode_q;
         eng_ctrl_q.disc_en            <= disc_en_q;
         eng_ctrl_q.det_en             <= det_class_en_q[3:0] & ~manual_port;
         eng_ctrl_q.class_en           <= det_class_en_q[7:4] & ~manual_port;
         eng_ctrl_q.det_run            <= (reg_wr && hit(reg_addr, ADDR_DET_CLASS_EN))
                                          ? reg_wdata[3:0] & manual_port : 4'h0;
         eng_ctrl_q.class_run          <= (reg_wr && hit(reg_addr, ADDR_DET_CLASS_EN))
                                          ? reg_wdata[7:4] & manual_port : 4'h0;
         eng_ctrl_q.remove_power       <= discon_now | eng_rpt.overcurrent_limit_fault;
         eng_ctrl_q.disconnect_delay   <= timer_sel_q[TMR_DIS_LSB +: 2];
         eng_ctrl_q.overcurrent_window <= timer_sel_q[TMR_OVERCURRENT_LIMIT_LSB +: 2];
         eng_ctrl_q.startup_window     <= timer_sel_q[TMR_START_LSB +: 2];
      end
   end

   // Read port: data captured on the same edge the alias clears, so the
   // value returned is the one before the clear
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata_q  <= 8'h00;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_INT_SUMMARY:                   reg_rdata_q <= summary_q;
               ADDR_INT_MASK:                      reg_rdata_q <= mask_q;
               ADDR_PWR_EVT, ADDR_PWR_EVT_CLR:     reg_rdata_q <= pwr_evt_q;
               ADDR_DET_EVT, ADDR_DET_EVT_CLR:     reg_rdata_q <= det_evt_q;
               ADDR_FLT_EVT, ADDR_FLT_EVT_CLR:     reg_rdata_q <= flt_evt_q;
               ADDR_START_EVT, ADDR_START_EVT_CLR: reg_rdata_q <= start_evt_q;
               ADDR_SUP_EVT, ADDR_SUP_EVT_CLR:     reg_rdata_q <= sup_evt_q;
               8'h0C, 8'h0D, 8'h0E, ADDR_PORT4_RESULT:
                  reg_rdata_q <= result_q[reg_addr[1:0]];
               ADDR_PWR_STATUS:   reg_rdata_q <= {pwr_good_q, pwr_on_q};
               ADDR_STRAP_LEVELS: reg_rdata_q <= {2'h0, strap_sync_q[4:1], 1'b0,
                                                  strap_sync_q[STRAP_AUTO_BIT]};
               ADDR_PORT_MODE:    reg_rdata_q <= mode_q;
               ADDR_LOW_CUR_EN:   reg_rdata_q <= {4'h0, disc_en_q};
               ADDR_DET_CLASS_EN: reg_rdata_q <= det_class_en_q;
               ADDR_FAULT_TIMER:  reg_rdata_q <= timer_sel_q;
               ADDR_MISC_CFG:     reg_rdata_q <= misc_q;
               default:           reg_rdata_q <= 8'h00; // Pushbuttons, gaps
            endcase
         end
      end
   end

endmodule : pse_event_regs

/* File: testbench/pse_event_regs_checker.sv */
// Port assertions for the event and status register bank
module pse_event_regs_checker
   import pse_regs_pkg::*;
(
   // Clock and reset
   input wire logic           clk_sys,
   input wire logic           sys_rst,
   // Register access
   input wire logic [7:0]     reg_addr,
   input wire logic           reg_wr,
   input wire logic [7:0]     reg_wdata,
   input wire logic           reg_rd,
   input wire logic [7:0]     reg_rdata_q,
   input wire logic           reg_rvalid_q,
   input wire logic           alert_resp_en_q,
   // Engines, straps and alert pin
   input wire engine_report_t eng_rpt,
   input wire engine_ctrl_t   eng_ctrl_q,
   input wire logic           auto_strap,
   input wire logic [3:0]     bus_addr_straps,
   input wire logic           alert_i,
   input wire logic           alert_o_q,
   input wire logic           alert_oe_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Read answer timing and reserved read bits
   property p_rvalid; reg_rvalid_q == $past(reg_rd); endproperty
   a_rvalid: assert property (p_rvalid) else $error("rvalid off");
   property p_strap; reg_rd && reg_addr == ADDR_STRAP_LEVELS |=> !(reg_rdata_q & 8'hC2); endproperty
   a_strap: assert property (p_strap) else $error("strap spare bits");
   property p_start; reg_rd && reg_addr inside {8'h08, 8'h09} |=> !reg_rdata_q[7:4]; endproperty
   a_start: assert property (p_start) else $error("startup upper bits");
   property p_sup; reg_rd && reg_addr inside {8'h0A, 8'h0B} |=> !(reg_rdata_q & 8'h4F); endproperty
   a_sup: assert property (p_sup) else $error("supply spare bits");
   // Engine orders follow their causes one clock later
   property p_cut; eng_rpt.overcurrent_limit_fault[0] |=> eng_ctrl_q.remove_power[0]; endproperty
   a_cut: assert property (p_cut) else $error("no turn-off");
   property p_run;
      reg_wr && reg_addr == ADDR_DET_CLASS_EN && reg_wdata[0]
         && eng_ctrl_q.port_mode[1:0] == MODE_MANUAL |=> eng_ctrl_q.det_run[0];
   endproperty
   a_run: assert property (p_run) else $error("no manual run");
   // Alert pin stays released while the pin enable is off
   property p_off; !alert_resp_en_q && !$past(alert_resp_en_q) |-> !alert_oe_q; endproperty
   a_off: assert property (p_off) else $error("alert while disabled");
   property p_od; alert_o_q == 1'b0; endproperty
   a_od: assert property (p_od) else $error("alert driven high");
   c_alert: cover property ($rose(alert_oe_q));
   c_run: cover property (eng_ctrl_q.det_run[0]);
   c_cut: cover property (eng_ctrl_q.remove_power[0]);
endmodule : pse_event_regs_checker
bind pse_event_regs pse_event_regs_checker pse_event_regs_checker_i (
   .clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q,
   .reg_rvalid_q, .alert_resp_en_q, .eng_rpt, .eng_ctrl_q, .auto_strap,
   .bus_addr_straps, .alert_i, .alert_o_q, .alert_oe_q
);

/* File: testbench/port_engine_model.sv */
// Behavioural port engines answering the register bank
module port_engine_model
   import pse_regs_pkg::*;
#(
   parameter logic [2:0] DET_RES = 3'h4,
   parameter logic [2:0] CLS_RES = 3'h2
)
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // Bank controls and bench orders {on, fault, low, supply}
   input  wire engine_ctrl_t ctrl,
   input  wire logic [14:0]  cmd,
   // Reports
   output engine_report_t    rpt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] on_q;
   logic [7:0] done_q;
   // Switch state; a turn-off order beats a turn-on
   always_ff @(posedge clk_sys) begin
      on_q <= sys_rst ? 4'h0 : (on_q | cmd[14:11]) & ~ctrl.remove_power;
   end
   // A manual cycle ends one clock after its order, then the port idles
   always_ff @(posedge clk_sys) begin
      done_q <= sys_rst ? 8'h00 : {ctrl.class_run, ctrl.det_run};
   end
   // Faults and low current only arise on powered ports
   always_comb begin
      rpt = '0;
      rpt.pwr_on = on_q;
      rpt.pwr_good = on_q;
      rpt.det_done = done_q[3:0];
      rpt.class_done = done_q[7:4];
      rpt.det_result = {4{DET_RES}};
      rpt.class_result = {4{CLS_RES}};
      rpt.overcurrent_limit_fault = cmd[10:7] & on_q;
      rpt.low_current = cmd[6:3] & on_q;
      {rpt.over_temp, rpt.vdd_undervoltage_lockout, rpt.vee_undervoltage_lockout} = cmd[2:0];
   end
endmodule : port_engine_model

/* File: testbench/quad_pse_event_status_regs_tb_top.sv */
// Self-checking bench for the event and status register bank
module quad_pse_event_status_regs_tb_top import pse_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] DR = 3'h4;
   localparam logic [2:0] CR = 3'h2;
   logic clk_sys, sys_rst, reg_wr, reg_rd, auto_strap, reg_rvalid_q;
   logic alert_resp_en_q, alert_i, alert_o_q, alert_oe_q;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, m;
   logic [3:0] bus_addr_straps;
   logic [14:0] cmd;
   engine_report_t eng_rpt;
   engine_ctrl_t eng_ctrl_q;
   int mismatches, total_checks, cyc;
   // Open-drain line with pull-up
   assign alert_i = alert_oe_q ? alert_o_q : 1'b1;
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   pse_event_regs pse_event_regs_i (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rd, .reg_rdata_q, .reg_rvalid_q, .alert_resp_en_q, .eng_rpt, .eng_ctrl_q,
      .auto_strap, .bus_addr_straps, .alert_i, .alert_o_q, .alert_oe_q);
   port_engine_model #(.DET_RES(DR), .CLS_RES(CR)) port_engine_model_i (.clk_sys,
      .sys_rst, .ctrl(eng_ctrl_q), .cmd, .rpt(eng_rpt));
   // Expected port result from detect and class codes
   function automatic logic [7:0] exp_result(input logic [2:0] d, input logic [2:0] c);
      return {1'b0, c, 1'b0, d};
   endfunction : exp_result
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", reg_rdata_q, e);
   endtask : rd
   // One-cycle engine report, then time for latch, summary and pin
   task automatic kick(input logic [14:0] c);
      @(posedge clk_sys);
      cmd <= c;
      @(posedge clk_sys);
      cmd <= 15'h0;
      repeat (5) @(posedge clk_sys);
      #1;
   endtask : kick
   task automatic end_of_test;
      if (mismatches == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   // Hang guard, far above the run length
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'h13959246));
      {reg_wr, reg_rd, reg_addr, reg_wdata, cmd} = '0;
      {auto_strap, sys_rst} = 2'h3;
      bus_addr_straps = 4'($urandom);
      m = 8'($urandom);
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(ADDR_PORT_MODE, 8'hFF);
      rd(ADDR_STRAP_LEVELS, {2'h0, bus_addr_straps, 2'h1});
      rd(ADDR_MISC_CFG, MISC_RESET);
      for (int a = 0; a < 12; a++) begin
         rd(8'(a), 8'h00);
      end
      rd(8'h15, 8'h00);
      wr(ADDR_INT_MASK, m);
      rd(ADDR_INT_MASK, m);
      wr(ADDR_FAULT_TIMER, m);
      rd(ADDR_FAULT_TIMER, {2'h0, m[5:0]});
      chk("disconnect_delay", {6'h0, eng_ctrl_q.disconnect_delay}, {6'h0, m[1:0]});
      wr(ADDR_INT_SUMMARY, 8'hFF);
      rd(ADDR_INT_SUMMARY, 8'h00);
      wr(ADDR_INT_MASK, 8'h10);
      wr(ADDR_PORT_MODE, 8'h55);
      wr(ADDR_DET_CLASS_EN, 8'h11);
      kick(15'h0);
      rd(ADDR_DET_EVT, 8'h11);
      rd(ADDR_INT_SUMMARY, 8'h0C);
      rd(ADDR_DET_EVT_CLR, 8'h11);
      rd(ADDR_DET_EVT, 8'h00);
      kick(15'h0800);
      rd(ADDR_PWR_STATUS, 8'h11);
      rd(ADDR_PWR_EVT, 8'h11);
      rd(ADDR_PORT1_RESULT, exp_result(DR, CR));
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h00);
      kick(15'h0080);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h01);
      chk("alert_i", {7'h0, alert_i}, 8'h00);
      rd(ADDR_FLT_EVT, 8'h01);
      rd(ADDR_PWR_STATUS, 8'h00);
      rd(ADDR_PORT1_RESULT, 8'h00);
      wr(ADDR_INT_MASK, 8'h00);
      kick(15'h0);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h00);
      wr(ADDR_LOW_CUR_EN, 8'h01);
      kick(15'h1800);
      kick(15'h0018);
      rd(ADDR_FLT_EVT_CLR, 8'h11);
      rd(ADDR_PWR_STATUS, 8'h22);
      wr(ADDR_RESET_PB, 8'h80);
      rd(ADDR_INT_SUMMARY, 8'h00);
      rd(ADDR_PWR_EVT, 8'h00);
      wr(ADDR_INT_MASK, 8'hFF);
      wr(ADDR_MISC_CFG, 8'h00);
      kick(15'h0007);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h00);
      chk("resp_en", {7'h0, alert_resp_en_q}, 8'h00);
      rd(ADDR_SUP_EVT, 8'hB0);
      rd(ADDR_INT_SUMMARY, 8'h80);
      wr(ADDR_MISC_CFG, 8'h80);
      wr(ADDR_RESET_PB, 8'h80);
      kick(15'h0004);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h01);
      wr(ADDR_RESET_PB, 8'h80);
      kick(15'h0);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h00);
      rd(ADDR_INT_SUMMARY, 8'h00);
      kick(15'h0004);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h01);
      wr(ADDR_RESET_PB, 8'h40);
      kick(15'h0002);
      chk("alert_oe", {7'h0, alert_oe_q}, 8'h00);
      rd(ADDR_SUP_EVT, 8'hA0);
      end_of_test();
   end
endmodule : quad_pse_event_status_regs_tb_top
